// *** inc/dwsr_map.vh ***
`ifndef DWSR_MAP_VH
`define DWSR_MAP_VH

// ************************************************
// Slave address
// ************************************************
// Fixed upper three address bits, below them the four strap bits
`define DWSR_DEV_TYPE 3'h2
`define DWSR_RW_BIT 0

// ************************************************
// Command byte layout
// ************************************************
`define DWSR_CMD_OP 7:4
`define DWSR_CMD_POT 2
`define DWSR_CMD_IDX 1:0

// Operation codes
`define DWSR_OP_RD_WIPER 4'h9
`define DWSR_OP_WR_WIPER 4'hA
`define DWSR_OP_RD_SAVED 4'hB
`define DWSR_OP_WR_SAVED 4'hC
`define DWSR_OP_SAVED_TO_WIPER 4'hD
`define DWSR_OP_WIPER_TO_SAVED 4'hE
`define DWSR_OP_INCDEC 4'h2

// Data byte bit that chooses up (1) or down (0) in step mode
`define DWSR_STEP_UP_BIT 0

// ************************************************
// Counts, limits and reset values
// ************************************************
`define DWSR_BYTE_BITS 4'h8
`define DWSR_BYTE_ADDR 2'h0
`define DWSR_BYTE_CMD 2'h1
`define DWSR_BYTE_DATA 2'h2
`define DWSR_WIPER_MIN 6'h00
`define DWSR_WIPER_MAX 6'h3F
`define DWSR_WIPER_RESET 6'h00
`define DWSR_RECALL_IDX 2'h0
`define DWSR_POT0 1'b0
`define DWSR_POT1 1'b1
`define DWSR_SAVED_INIT 6'h20

`endif

// *** rtl/dwsr_mem.v ***
`timescale 1ns/1ps
`include "dwsr_map.vh"
// ************************************************
// Saved-setting store, one write and one read port
// ************************************************
module dwsr_mem #(
   parameter WIDTH = 6,
   parameter AW = 3,
   parameter [5:0] INIT = `DWSR_SAVED_INIT
) (
   input wire ref_clk,
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [WIDTH-1:0] wr_data,
   input wire [AW-1:0] rd_addr,
   output reg [WIDTH-1:0] rd_data
);

   // Storage cells, untouched by reset since they are nonvolatile
   reg [WIDTH-1:0] cells [0:(1<<AW)-1];
   integer i;

   // Factory contents before any write
   initial begin
      for (i = 0; i < (1 << AW); i = i + 1) begin
         cells[i] = INIT[WIDTH-1:0];
      end
   end

   // Write port and registered read port
   always @(posedge ref_clk) begin
      if (wr_en) begin
         cells[wr_addr] <= wr_data;
      end
      rd_data <= cells[rd_addr];
   end

endmodule

// *** rtl/dwsr_core.v ***
`timescale 1ns/1ps
`include "dwsr_map.vh"
// ************************************************
// Dual wiper control with serial slave interface
// ************************************************
module dwsr_core #(
   parameter WIDTH = 6,
   parameter TAPS = 64
) (
   input wire ref_clk,
   input wire reset_n,
   input wire scl,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   input wire bus_id_pin_0,
   input wire bus_id_pin_1,
   input wire bus_id_pin_2,
   input wire bus_id_pin_3,
   output reg [WIDTH-1:0] wiper_position_reg_0,
   output reg [WIDTH-1:0] wiper_position_reg_1,
   output reg [TAPS-1:0] tap_sel_0,
   output reg [TAPS-1:0] tap_sel_1
);

   // ************************************************
   // States
   // ************************************************
   localparam [2:0] ST_BOOT0 = 3'h0; // Address first saved setting of pot 0
   localparam [2:0] ST_BOOT1 = 3'h1; // Load pot 0, address pot 1
   localparam [2:0] ST_BOOT2 = 3'h2; // Load pot 1
   localparam [2:0] ST_IDLE = 3'h3; // Waiting for a start condition
   localparam [2:0] ST_RX = 3'h4; // Receiving a byte
   localparam [2:0] ST_RACK = 3'h5; // Driving our acknowledge
   localparam [2:0] ST_TX = 3'h6; // Sending a byte
   localparam [2:0] ST_TACK = 3'h7; // Sampling the master's acknowledge

   // ************************************************
   // Functions
   // ************************************************
   // One-hot tap decode of a wiper code
   function [TAPS-1:0] dwsr_onehot;
      input [WIDTH-1:0] code;
      begin
         dwsr_onehot = {{(TAPS-1){1'b0}}, 1'b1} << code;
      end
   endfunction

   // Single saturating step up or down
   function [WIDTH-1:0] dwsr_step;
      input [WIDTH-1:0] code;
      input up;
      begin
         if (up) begin
            dwsr_step = (code == `DWSR_WIPER_MAX) ? code : code + {{(WIDTH-1){1'b0}}, 1'b1};
         end else begin
            dwsr_step = (code == `DWSR_WIPER_MIN) ? code : code - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   endfunction

   // ************************************************
   // Pin synchronisers
   // ************************************************
   reg scl_s1, scl_s2, scl_d; // Clock pin stages and edge history
   reg sda_s1, sda_s2, sda_d; // Data pin stages and edge history
   reg [3:0] id_s1, id_s2; // Strap pin stages

   // Two flops per pin, then one more on clock and data for edge finding
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
         id_s1 <= 4'h0;
         id_s2 <= 4'h0;
      end else begin
         scl_s1 <= scl;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
         id_s1 <= {bus_id_pin_3, bus_id_pin_2, bus_id_pin_1, bus_id_pin_0};
         id_s2 <= id_s1;
      end
   end

   // Bus events seen on the synchronised pins
   wire scl_rise = scl_s2 & ~scl_d;
   wire scl_fall = ~scl_s2 & scl_d;
   wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
   wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

   // ************************************************
   // Transfer state
   // ************************************************
   reg [2:0] state; // Main sequencer
   reg [7:0] shift; // Receive and transmit shifter
   reg [3:0] bit_cnt; // Bits moved in the current byte
   reg [1:0] byte_idx; // Address, command, then data bytes
   reg rw_read; // Current transfer is a read
   reg [7:0] cmd; // Last accepted command byte
   reg tx_nack; // Master declined further read bytes
   reg mem_we; // Saved-setting write strobe
   reg [2:0] mem_wa; // Saved-setting write address
   reg [WIDTH-1:0] mem_wd; // Saved-setting write data
   reg [2:0] rd_addr; // Saved-setting read address
   wire [WIDTH-1:0] rd_data; // Saved-setting read data

   // Fields of the command byte
   wire [3:0] cmd_op = cmd[`DWSR_CMD_OP];
   wire cmd_pot = cmd[`DWSR_CMD_POT];
   wire [1:0] cmd_idx = cmd[`DWSR_CMD_IDX];

   // Wiper of the addressed potentiometer
   wire [WIDTH-1:0] sel_wiper = cmd_pot ? wiper_position_reg_1 : wiper_position_reg_0;

   // Byte returned on a read
   wire [7:0] tx_byte = {2'h0, (cmd_op == `DWSR_OP_RD_WIPER) ? sel_wiper : rd_data};

   // Address match against fixed type and straps
   wire addr_hit = (shift[7:1] == {`DWSR_DEV_TYPE, id_s2});

   // ************************************************
   // Read address selection
   // ************************************************
   // Boot reads the first saved settings, otherwise the command target
   always @* begin
      case (state)
         ST_BOOT0: rd_addr = {`DWSR_POT0, `DWSR_RECALL_IDX};
         ST_BOOT1: rd_addr = {`DWSR_POT1, `DWSR_RECALL_IDX};
         // During the command ack the new target is still only in the shifter
         ST_RACK: rd_addr = (byte_idx == `DWSR_BYTE_CMD) ?
            {shift[`DWSR_CMD_POT], shift[`DWSR_CMD_IDX]} : {cmd_pot, cmd_idx};
         default: rd_addr = {cmd_pot, cmd_idx};
      endcase
   end

   // ************************************************
   // Command execution decode
   // ************************************************
   reg exec_wip; // Wiper of the command byte's pot takes exec_val
   reg exec_mem; // Saved setting at cmd target takes exec_val
   reg [WIDTH-1:0] exec_val; // Value to store

   // Copies act after the command byte, writes after each data byte
   always @* begin
      exec_wip = 1'b0;
      exec_mem = 1'b0;
      exec_val = shift[WIDTH-1:0];
      if (byte_idx == `DWSR_BYTE_CMD) begin
         case (shift[`DWSR_CMD_OP])
            `DWSR_OP_SAVED_TO_WIPER: begin
               exec_wip = 1'b1;
               exec_val = rd_data;
            end
            `DWSR_OP_WIPER_TO_SAVED: begin
               exec_mem = 1'b1;
               exec_val = shift[`DWSR_CMD_POT] ? wiper_position_reg_1 : wiper_position_reg_0;
            end
            default: begin
               exec_wip = 1'b0;
            end
         endcase
      end else if (byte_idx == `DWSR_BYTE_DATA) begin
         case (cmd_op)
            `DWSR_OP_WR_WIPER: exec_wip = 1'b1;
            `DWSR_OP_WR_SAVED: exec_mem = 1'b1;
            `DWSR_OP_INCDEC: begin
               exec_wip = 1'b1;
               exec_val = dwsr_step(sel_wiper, shift[`DWSR_STEP_UP_BIT]);
            end
            default: begin
               exec_wip = 1'b0;
            end
         endcase
      end
   end

   // ************************************************
   // Main sequencer
   // ************************************************
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         state <= ST_BOOT0;
         shift <= 8'h00;
         bit_cnt <= 4'h0;
         byte_idx <= `DWSR_BYTE_ADDR;
         rw_read <= 1'b0;
         cmd <= 8'h00;
         tx_nack <= 1'b0;
         mem_we <= 1'b0;
         mem_wa <= 3'h0;
         mem_wd <= `DWSR_WIPER_RESET;
         sda_oe <= 1'b0;
         wiper_position_reg_0 <= `DWSR_WIPER_RESET;
         wiper_position_reg_1 <= `DWSR_WIPER_RESET;
      end else begin
         mem_we <= 1'b0;
         case (state)
            // Recall after reset, bus ignored meanwhile
            ST_BOOT0: begin
               state <= ST_BOOT1;
            end
            ST_BOOT1: begin
               wiper_position_reg_0 <= rd_data;
               state <= ST_BOOT2;
            end
            ST_BOOT2: begin
               wiper_position_reg_1 <= rd_data;
               state <= ST_IDLE;
            end
            default: begin
               if (bus_start) begin
                  // Start or repeated start opens a new address byte
                  state <= ST_RX;
                  bit_cnt <= 4'h0;
                  byte_idx <= `DWSR_BYTE_ADDR;
                  sda_oe <= 1'b0;
               end else if (bus_stop) begin
                  state <= ST_IDLE;
                  sda_oe <= 1'b0;
               end else begin
                  case (state)
                     ST_RX: begin
                        if (scl_rise) begin
                           shift <= {shift[6:0], sda_s2};
                           bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == `DWSR_BYTE_BITS) begin
                           if (byte_idx == `DWSR_BYTE_ADDR) begin
                              if (addr_hit) begin
                                 rw_read <= shift[`DWSR_RW_BIT];
                                 sda_oe <= 1'b1;
                                 state <= ST_RACK;
                              end else begin
                                 state <= ST_IDLE;
                              end
                           end else begin
                              sda_oe <= 1'b1;
                              state <= ST_RACK;
                           end
                        end
                     end
                     ST_RACK: begin
                        if (scl_fall) begin
                           bit_cnt <= 4'h0;
                           if (byte_idx == `DWSR_BYTE_CMD) begin
                              cmd <= shift;
                           end
                           if (byte_idx != `DWSR_BYTE_DATA) begin
                              byte_idx <= byte_idx + 2'h1;
                           end
                           // Store whatever this byte asked for
                           if (exec_wip) begin
                              if (byte_idx == `DWSR_BYTE_CMD ? shift[`DWSR_CMD_POT] : cmd_pot) begin
                                 wiper_position_reg_1 <= exec_val;
                              end else begin
                                 wiper_position_reg_0 <= exec_val;
                              end
                           end
                           if (exec_mem) begin
                              mem_we <= 1'b1;
                              mem_wa <= (byte_idx == `DWSR_BYTE_CMD) ?
                                 {shift[`DWSR_CMD_POT], shift[`DWSR_CMD_IDX]} : {cmd_pot, cmd_idx};
                              mem_wd <= exec_val;
                           end
                           if (rw_read && byte_idx == `DWSR_BYTE_ADDR) begin
                              // Read: first data bit goes out now
                              shift <= tx_byte;
                              sda_oe <= ~tx_byte[7];
                              bit_cnt <= 4'h1;
                              state <= ST_TX;
                           end else begin
                              sda_oe <= 1'b0;
                              state <= ST_RX;
                           end
                        end
                     end
                     ST_TX: begin
                        if (scl_fall) begin
                           if (bit_cnt == `DWSR_BYTE_BITS) begin
                              sda_oe <= 1'b0;
                              state <= ST_TACK;
                           end else begin
                              sda_oe <= ~shift[6];
                              shift <= {shift[6:0], 1'b0};
                              bit_cnt <= bit_cnt + 4'h1;
                           end
                        end
                     end
                     ST_TACK: begin
                        if (scl_rise) begin
                           tx_nack <= sda_s2;
                        end else if (scl_fall) begin
                           if (tx_nack) begin
                              state <= ST_IDLE;
                           end else begin
                              // Master wants more: resend current value
                              shift <= tx_byte;
                              sda_oe <= ~tx_byte[7];
                              bit_cnt <= 4'h1;
                              state <= ST_TX;
                           end
                        end
                     end
                     default: begin
                        sda_oe <= 1'b0;
                     end
                  endcase
               end
            end
         endcase
      end
   end

   // ************************************************
   // Pin drive and tap decode
   // ************************************************
   // Data pin only ever pulls low; tap switches follow the wipers
   always @(posedge ref_clk) begin
      sda_out <= 1'b0;
      if (!reset_n) begin
         tap_sel_0 <= dwsr_onehot(`DWSR_WIPER_RESET);
         tap_sel_1 <= dwsr_onehot(`DWSR_WIPER_RESET);
      end else begin
         tap_sel_0 <= dwsr_onehot(wiper_position_reg_0);
         tap_sel_1 <= dwsr_onehot(wiper_position_reg_1);
      end
   end

   // ************************************************
   // Saved settings
   // ************************************************
   dwsr_mem #(
      .WIDTH(WIDTH),
      .AW(3),
      .INIT(`DWSR_SAVED_INIT)
   ) u_mem (
      .ref_clk(ref_clk),
      .wr_en(mem_we),
      .wr_addr(mem_wa),
      .wr_data(mem_wd),
      .rd_addr(rd_addr),
      .rd_data(rd_data)
   );

endmodule

// *** tb/dwsr_core_assertions.sv ***
`timescale 1ns/1ps
// ************************************************
// Port checker for the dual wiper core
// ************************************************
module dwsr_core_checker #(
   parameter WIDTH = 6,
   parameter TAPS = 64
) (
   input wire ref_clk,
   input wire reset_n,
   input wire scl,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   input wire [WIDTH-1:0] wiper_position_reg_0,
   input wire [WIDTH-1:0] wiper_position_reg_1,
   input wire [TAPS-1:0] tap_sel_0,
   input wire [TAPS-1:0] tap_sel_1
);
   // Cycles the serial clock has been low, saturating
   reg [3:0] low_cnt;
   // Cycles since reset release, saturating
   reg [3:0] boot_cnt;
   // Count the low phase of the serial clock
   always @(posedge ref_clk) begin
      if (scl) begin
         low_cnt <= 4'h0;
      end else if (low_cnt != 4'hF) begin
         low_cnt <= low_cnt + 4'h1;
      end
   end
   // Count the boot window
   always @(posedge ref_clk) begin
      if (!reset_n) begin
         boot_cnt <= 4'h0;
      end else if (boot_cnt != 4'hF) begin
         boot_cnt <= boot_cnt + 4'h1;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // Falling serial clock, then the answer window in the low phase
   sequence s_scl_fall;
      scl ##1 !scl;
   endsequence
   sequence s_low_window;
      low_cnt >= 4'h2 && low_cnt <= 4'h8;
   endsequence
   sequence s_boot_window;
      boot_cnt < 4'h6;
   endsequence
   chk_tap_follow_0: assert property (tap_sel_0 == (64'h0000_0000_0000_0001 << $past(wiper_position_reg_0))) else $error("tap 0 not one-hot on wiper 0");
   chk_tap_follow_1: assert property (tap_sel_1 == (64'h0000_0000_0000_0001 << $past(wiper_position_reg_1))) else $error("tap 1 not one-hot on wiper 1");
   chk_drain_only: assert property (sda_out == 1'b0) else $error("data line driven high");
   chk_oe_low_phase: assert property ($changed(sda_oe) |-> s_low_window) else $error("data drive changed outside clock low phase");
   chk_wiper0_timing: assert property ($changed(wiper_position_reg_0) |-> s_boot_window or s_low_window) else $error("wiper 0 moved off the bus clock");
   chk_wiper1_timing: assert property ($changed(wiper_position_reg_1) |-> s_boot_window or s_low_window) else $error("wiper 1 moved off the bus clock");
   chk_pots_apart: assert property (!($changed(wiper_position_reg_0) && $changed(wiper_position_reg_1))) else $error("both wipers moved together");
   chk_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> (!sda_oe && wiper_position_reg_0 == 6'h00 && tap_sel_1 == 64'h0000_0000_0000_0001)) else $error("reset values wrong");
   cover property (s_scl_fall ##[2:6] $changed(sda_oe));
endmodule
bind dwsr_core dwsr_core_checker #(.WIDTH(WIDTH), .TAPS(TAPS)) dwsr_core_checker_i (.ref_clk(ref_clk), .reset_n(reset_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .wiper_position_reg_0(wiper_position_reg_0), .wiper_position_reg_1(wiper_position_reg_1), .tap_sel_0(tap_sel_0), .tap_sel_1(tap_sel_1));

// *** tb/dwsr_master.sv ***
`timescale 1ns/1ps
// ************************************************
// Two-wire bus master model
// ************************************************
module dwsr_master (
   input wire ref_clk,
   input wire sda,
   output reg scl,
   output reg m_pull
);
   // Bus idles released, clock standing high
   initial begin
      scl = 1'b1;
      m_pull = 1'b0;
   end
   // One clock pulse: data set in low phase, sampled mid high phase
   task bit_io(input b, output r);
      begin
         @(posedge ref_clk) m_pull <= !b;
         repeat (9) @(posedge ref_clk);
         scl <= 1'b1;
         repeat (5) @(posedge ref_clk);
         r = sda;
         repeat (5) @(posedge ref_clk);
         scl <= 1'b0;
      end
   endtask
   // Data falls while clock is high
   task start_cond;
      begin
         @(posedge ref_clk) m_pull <= 1'b1;
         repeat (10) @(posedge ref_clk);
         scl <= 1'b0;
      end
   endtask
   // Data rises while clock is high
   task stop_cond;
      begin
         @(posedge ref_clk) m_pull <= 1'b1;
         repeat (9) @(posedge ref_clk);
         scl <= 1'b1;
         repeat (10) @(posedge ref_clk);
         m_pull <= 1'b0;
         repeat (10) @(posedge ref_clk);
      end
   endtask
   // Byte out MSB first, then the device acknowledge
   task send_byte(input [7:0] d, output ack);
      reg r;
      integer i;
      begin
         for (i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
         end
         bit_io(1'b1, r);
         ack = !r;
      end
   endtask
   // Byte in MSB first, then master ack or nack
   task recv_byte(input last, output [7:0] d);
      reg r;
      integer i;
      begin
         for (i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
         end
         bit_io(last, r);
      end
   endtask
endmodule

// *** tb/test_dwsr_core.sv ***
`timescale 1ns/1ps
`include "dwsr_map.vh"
// ************************************************
// Testbench for the dual wiper core
// ************************************************
module test_dwsr_core;
   reg ref_clk; // Core clock
   reg reset_n; // Synchronous reset
   reg [3:0] straps; // Address strap levels
   wire scl; // Master serial clock
   wire m_pull; // Master pulls data low
   wire sda_out;
   wire sda_oe;
   wire [5:0] wiper_0;
   wire [5:0] wiper_1;
   wire [63:0] tap_0;
   wire [63:0] tap_1;
   // Open-drain data line with pull-up
   wire sda_line = (sda_oe ? sda_out : 1'b1) && !m_pull;
   integer miscompares;
   integer n_tests;
   integer i;
   reg ack;
   reg [7:0] rd_byte;
   dwsr_core dwsr_core_i (.ref_clk(ref_clk), .reset_n(reset_n), .scl(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .bus_id_pin_0(straps[0]), .bus_id_pin_1(straps[1]), .bus_id_pin_2(straps[2]),
      .bus_id_pin_3(straps[3]), .wiper_position_reg_0(wiper_0),
      .wiper_position_reg_1(wiper_1), .tap_sel_0(tap_0), .tap_sel_1(tap_1));
   dwsr_master dwsr_master_i (.ref_clk(ref_clk), .sda(sda_line), .scl(scl), .m_pull(m_pull));
   // Clock, 8 ns period
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Compare and count
   task chk(input string what, input [63:0] exp, input [63:0] got);
      begin
         n_tests++;
         if (exp !== got) begin
            $display("[ERR] %0s expected %0h seen %0h", what, exp, got);
            miscompares++;
         end
      end
   endtask
   // Counts and verdict
   task close_out;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, miscompares);
         if (miscompares == 0 && n_tests > 0) $display("verification passed");
         else $display("verification failed");
         $finish;
      end
   endtask
   // Start and address byte with expected acknowledge
   task addr(input [3:0] id, input rw, input exp);
      begin
         dwsr_master_i.start_cond;
         dwsr_master_i.send_byte({`DWSR_DEV_TYPE, id, rw}, ack);
         chk("address ack", exp, ack);
      end
   endtask
   // Command and n data bytes
   task wr(input [3:0] op, input pot, input [1:0] idx, input [5:0] d, input integer n);
      begin
         addr(straps, 1'b0, 1'b1);
         dwsr_master_i.send_byte({op, 1'b0, pot, idx}, ack);
         chk("command ack", 1'b1, ack);
         repeat (n) begin
            dwsr_master_i.send_byte({2'b00, d}, ack);
            chk("data ack", 1'b1, ack);
         end
         dwsr_master_i.stop_cond;
      end
   endtask
   // Command, then one read byte ended by nack
   task rd(input [3:0] op, input pot, input [1:0] idx, input [5:0] exp);
      begin
         wr(op, pot, idx, 6'h00, 0);
         addr(straps, 1'b1, 1'b1);
         dwsr_master_i.recv_byte(1'b1, rd_byte);
         dwsr_master_i.stop_cond;
         chk("read byte", {2'b00, exp}, rd_byte);
      end
   endtask
   // Wiper codes and one-hot taps at the ports
   task pots(input [5:0] e0, input [5:0] e1);
      begin
         chk("wiper 0", e0, wiper_0);
         chk("wiper 1", e1, wiper_1);
         chk("tap 0", 64'h0000_0000_0000_0001 << e0, tap_0);
         chk("tap 1", 64'h0000_0000_0000_0001 << e1, tap_1);
      end
   endtask
   // Main sequence
   initial begin
      miscompares = 0;
      n_tests = 0;
      reset_n = 1'b0;
      straps = 4'h5;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (20) @(posedge ref_clk);
      pots(`DWSR_SAVED_INIT, `DWSR_SAVED_INIT);
      $display("test boot done");
      // Every strap code answers, one flipped bit is refused
      for (i = 0; i < 16; i++) begin
         @(posedge ref_clk) straps <= i[3:0];
         repeat (10) @(posedge ref_clk);
         addr(i[3:0] ^ (4'h1 << (i % 4)), 1'b0, 1'b0);
         dwsr_master_i.stop_cond;
         addr(i[3:0], 1'b0, 1'b1);
         dwsr_master_i.stop_cond;
      end
      $display("test address done");
      wr(`DWSR_OP_WR_WIPER, 1'b0, 2'h0, 6'h3F, 1);
      wr(`DWSR_OP_WR_WIPER, 1'b1, 2'h0, 6'h00, 1);
      pots(6'h3F, 6'h00);
      rd(`DWSR_OP_RD_WIPER, 1'b0, 2'h0, 6'h3F);
      rd(`DWSR_OP_RD_WIPER, 1'b1, 2'h0, 6'h00);
      wr(`DWSR_OP_WR_SAVED, 1'b0, 2'h3, 6'h15, 1);
      wr(`DWSR_OP_WR_SAVED, 1'b1, 2'h3, 6'h2A, 1);
      rd(`DWSR_OP_RD_SAVED, 1'b0, 2'h3, 6'h15);
      rd(`DWSR_OP_RD_SAVED, 1'b1, 2'h3, 6'h2A);
      // Master ack asks for the same value again, nack ends
      wr(`DWSR_OP_RD_SAVED, 1'b1, 2'h3, 6'h00, 0);
      addr(straps, 1'b1, 1'b1);
      dwsr_master_i.recv_byte(1'b0, rd_byte);
      chk("read byte 1", 8'h2A, rd_byte);
      dwsr_master_i.recv_byte(1'b1, rd_byte);
      chk("read byte 2", 8'h2A, rd_byte);
      dwsr_master_i.stop_cond;
      $display("test access done");
      wr(`DWSR_OP_SAVED_TO_WIPER, 1'b0, 2'h3, 6'h00, 0);
      pots(6'h15, 6'h00);
      wr(`DWSR_OP_WIPER_TO_SAVED, 1'b0, 2'h1, 6'h00, 0);
      rd(`DWSR_OP_RD_SAVED, 1'b0, 2'h1, 6'h15);
      $display("test copy done");
      wr(`DWSR_OP_WR_WIPER, 1'b0, 2'h0, 6'h3E, 1);
      wr(`DWSR_OP_INCDEC, 1'b0, 2'h0, 6'h01, 2);
      wr(`DWSR_OP_WR_WIPER, 1'b1, 2'h0, 6'h01, 1);
      wr(`DWSR_OP_INCDEC, 1'b1, 2'h0, 6'h00, 2);
      pots(6'h3F, 6'h00);
      wr(`DWSR_OP_INCDEC, 1'b0, 2'h0, 6'h00, 1);
      pots(6'h3E, 6'h00);
      $display("test step done");
      // Second reset recalls the kept first saved settings
      wr(`DWSR_OP_WR_SAVED, 1'b0, 2'h0, 6'h07, 1);
      wr(`DWSR_OP_WR_SAVED, 1'b1, 2'h0, 6'h38, 1);
      @(posedge ref_clk) reset_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (20) @(posedge ref_clk);
      pots(6'h07, 6'h38);
      $display("test recall done");
      close_out;
   end
   // Watchdog against a hung bus
   initial begin
      repeat (80000) @(posedge ref_clk);
      miscompares++;
      close_out;
   end
endmodule
